// ---- verilog/vpw_link_map.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef VPW_LINK_MAP_VH
`define VPW_LINK_MAP_VH
`define ADDR_CTRL_ONE 3'h0
`define ADDR_CTRL_TWO 3'h1
`define ADDR_STATE_VEC 3'h2
`define ADDR_DATA 3'h3
`define ADDR_POLARITY 3'h4
`define C1_IGNORE_MESSAGE 7
`define C1_TIMING_BASE_SELECT 6
`define C1_RHI 5
`define C1_RLO 4
`define C1_IE 1
`define C1_WCM 0
`define C2_ANALOG_LOOPBACK 7
`define C2_DIGITAL_LOOPBACK 6
`define C2_TEOD 3
`define CTRL_ONE_RST 8'hC0
`define CTRL_TWO_RST 8'hC0
`define SV_NONE 6'h00
`define SV_RXFULL 6'h0C
`define SV_TXEMPTY 6'h10
`define SV_INVALID 6'h1C
`define SV_CRC 6'h18
`define SV_WAKE 6'h20
`define SV_EOF 6'h04
`define T_EOF_US 10'h118
`define T_IFS_US 10'h12C
`define T_SOF_US 10'h0C8
`define T_SOF_MIN_US 10'h0A3
`define T_SHORT_US 10'h040
`define T_LONG_US 10'h080
`define T_BIT_MID_US 10'h060
`define T_BREAK_US 10'h0EF
`define T_ECHO_US 4'h8
`endif

// ---- verilog/vpw_link_controller.v ----
// vpw serial link controller: error handling, control registers, loopback
`timescale 1ns/100ps
`include "vpw_link_map.vh"
module vpw_link_controller (
  input wire clk_i,
  input wire rst_n_i,
  input wire clk_en_i,
  input wire cpu_wait_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire receive_pin_i,
  input wire final_stage_i,
  output reg transmit_pin_o,
  output wire xcvr_loop_o,
  output wire irq_o
);
  // three-stage sampler for the bus receive pin
  reg [2:0] rx_sync;
  reg rx_stable;
  reg [7:0] link_control_one;
  reg [7:0] link_control_two;
  reg rate_locked;
  reg receive_polarity;
  reg [7:0] link_data_register;
  reg tx_full;
  reg [7:0] rx_hold;
  reg receive_full_flag;
  reg crc_err;
  reg invalid_sym;
  reg eof_seen;
  reg arbitration_lost_flag;
  reg wake_flag;
  reg [2:0] presc;
  reg [4:0] frac;
  reg tick;
  reg [9:0] width_cnt;
  reg line_q;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] crc;
  reg [7:0] tx_shreg;
  reg tx_level;
  reg [9:0] tx_len;
  reg gate_rx;
  reg gate_tx;
  reg analog_loopback_q;
  reg digital_loopback_q;
  reg [3:0] echo_wait;
  localparam S_IDLE = 3'd0;
  localparam S_RX = 3'd1;
  localparam S_TX = 3'd2;
  localparam S_WAIT_EOF = 3'd3;
  localparam S_WAIT_SOF = 3'd4;
  localparam S_RESET = 3'd5;
  wire run = clk_en_i & ~(cpu_wait_i & link_control_one[`C1_WCM]);
  wire ignore_message = link_control_one[`C1_IGNORE_MESSAGE];
  wire analog_loopback = link_control_two[`C2_ANALOG_LOOPBACK];
  wire digital_loopback = link_control_two[`C2_DIGITAL_LOOPBACK];
  wire [1:0] rate = link_control_one[`C1_RHI:`C1_RLO];
  wire [2:0] div_top = (3'd1 << rate) - 3'd1;
  wire pin_lvl = rx_stable ^ ~receive_polarity;
  // loopback mux: digital loop wins over analog, neither sees the bus
  wire rx_line = digital_loopback ? tx_level : (analog_loopback ? final_stage_i : pin_lvl);
  wire [9:0] t_eof = `T_EOF_US;
  wire [9:0] t_ifs = `T_IFS_US;
  wire wr1 = wr_i && addr_i == `ADDR_CTRL_ONE;
  wire wr2 = wr_i && addr_i == `ADDR_CTRL_TWO;
  wire rd_sv = rd_i && addr_i == `ADDR_STATE_VEC;
  wire rd_dr = rd_i && addr_i == `ADDR_DATA;
  wire edge_seen = tick && rx_line != line_q;
  // one event per long pulse, so a vector read really clears what it flagged
  wire is_break = tick && line_q && rx_line == line_q
    && width_cnt == `T_BREAK_US;
  wire is_sof = edge_seen && line_q && width_cnt >= `T_SOF_MIN_US
    && width_cnt < `T_BREAK_US;
  wire idle_eof = !rx_line && width_cnt >= t_eof;
  wire idle_ifs = !rx_line && width_cnt >= t_ifs;
  reg [5:0] vector;

  assign xcvr_loop_o = analog_loopback;
  // level request; ignore masks everything but wakeup
  assign irq_o = link_control_one[`C1_IE] && vector != `SV_NONE
    && (!ignore_message || vector == `SV_WAKE);

  // priority encoder of pending sources, highest first
  always @* begin
    if (wake_flag)
      vector = `SV_WAKE;
    else if (invalid_sym)
      vector = `SV_INVALID;
    else if (crc_err)
      vector = `SV_CRC;
    else if (receive_full_flag)
      vector = `SV_RXFULL;
    else if (!tx_full && state == S_TX)
      vector = `SV_TXEMPTY;
    else if (eof_seen)
      vector = `SV_EOF;
    else
      vector = `SV_NONE;
  end

  // a change counts once stages two and three agree
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sync <= 3'h0;
      rx_stable <= 1'b0;
    end else if (clk_en_i) begin
      rx_sync <= {rx_sync[1:0], receive_pin_i};
      if (rx_sync[2] == rx_sync[1])
        rx_stable <= rx_sync[2];
    end
  end

  // prescaler plus fractional stretch giving one microsecond ticks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc <= 3'h0;
      frac <= 5'h00;
      tick <= 1'b0;
    end else if (run) begin
      tick <= 1'b0;
      if (presc >= div_top) begin
        presc <= 3'h0;
        frac <= frac + 5'h01;
        // binary 1.048576 MHz base slips one tick in 21 to stretch toward one microsecond
        if (!(link_control_one[`C1_TIMING_BASE_SELECT] && frac == 5'h14))
          tick <= 1'b1;
        if (frac == 5'h14)
          frac <= 5'h00;
      end else begin
        presc <= presc + 3'h1;
      end
    end
  end

  // registers: control, data and polarity
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_control_one <= `CTRL_ONE_RST;
      link_control_two <= `CTRL_TWO_RST;
      rate_locked <= 1'b0;
      receive_polarity <= 1'b0;
      link_data_register <= 8'h00;
      tx_full <= 1'b0;
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= 8'h00;
      if (rd_i) begin
        if (addr_i == `ADDR_CTRL_ONE)
          rdata_o <= link_control_one;
        else if (addr_i == `ADDR_CTRL_TWO)
          rdata_o <= link_control_two;
        else if (addr_i == `ADDR_STATE_VEC)
          rdata_o <= {2'b00, vector};
        else if (addr_i == `ADDR_DATA)
          rdata_o <= rx_hold;
        else if (addr_i == `ADDR_POLARITY)
          rdata_o <= {receive_polarity, 7'h00};
      end
      if (wr1) begin
        link_control_one[7:6] <= wdata_i[7:6];
        link_control_one[1:0] <= wdata_i[1:0];
        if (!rate_locked) begin
          link_control_one[5:4] <= wdata_i[5:4];
          rate_locked <= 1'b1;
        end
      end else if (run && ignore_message && (is_sof || is_break)) begin
        link_control_one[`C1_IGNORE_MESSAGE] <= 1'b0;
      end
      if (wr2)
        link_control_two <= wdata_i;
      if (wr_i && addr_i == `ADDR_POLARITY)
        receive_polarity <= wdata_i[7];
      if (wr_i && addr_i == `ADDR_DATA) begin
        link_data_register <= wdata_i;
        tx_full <= 1'b1;
      end else if (run && tick && state == S_TX && bit_cnt == 4'h8
                   && tx_len == 10'h000) begin
        tx_full <= 1'b0;
      end
    end
  end

  // symbol width measurement on the selected receive line
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      width_cnt <= 10'h000;
      line_q <= 1'b0;
    end else if (run && tick) begin
      line_q <= rx_line;
      if (rx_line != line_q)
        width_cnt <= 10'h000;
      else if (width_cnt != 10'h3FF)
        width_cnt <= width_cnt + 10'h001;
    end
  end

  // protocol state machine
  always @* begin
    next_state = state;
    case (state)
      S_RESET:
        if (!analog_loopback)
          next_state = S_WAIT_EOF;
      S_IDLE:
        if (is_sof && !ignore_message)
          next_state = S_RX;
        else if (tx_full && !gate_tx && idle_ifs)
          next_state = S_TX;
      S_RX:
        if (is_break)
          next_state = S_WAIT_SOF;
        else if (ignore_message)
          next_state = S_WAIT_EOF;
        else if (idle_eof)
          next_state = S_IDLE;
      S_TX:
        if (is_break)
          next_state = S_WAIT_SOF;
        // own echo lags through pin and sampler: compare once it settles
        else if (tick && echo_wait == 4'h0 && rx_line != tx_level)
          next_state = S_WAIT_EOF;
        else if (tick && bit_cnt == 4'h8 && tx_len == 10'h000)
          next_state = S_IDLE;
      S_WAIT_EOF:
        if (idle_eof)
          next_state = S_IDLE;
      S_WAIT_SOF:
        if (is_sof)
          next_state = S_RX;
      default:
        next_state = S_IDLE;
    endcase
    if (is_break && state != S_RESET)
      next_state = S_WAIT_SOF;
    if (analog_loopback)
      next_state = S_RESET;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      crc <= 8'hFF;
      tx_shreg <= 8'h00;
      tx_level <= 1'b0;
      tx_len <= 10'h000;
      transmit_pin_o <= 1'b0;
      rx_hold <= 8'h00;
      receive_full_flag <= 1'b0;
      crc_err <= 1'b0;
      invalid_sym <= 1'b0;
      eof_seen <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      wake_flag <= 1'b0;
      gate_rx <= 1'b0;
      gate_tx <= 1'b0;
      analog_loopback_q <= 1'b0;
      digital_loopback_q <= 1'b0;
      echo_wait <= 4'h0;
    end else if (run) begin
      state <= next_state;
      analog_loopback_q <= analog_loopback;
      digital_loopback_q <= digital_loopback;
      // leaving a loopback arms both idle gates
      if ((analog_loopback_q && !analog_loopback) || (digital_loopback_q && !digital_loopback)) begin
        gate_rx <= 1'b1;
        gate_tx <= 1'b1;
      end else begin
        if (idle_eof)
          gate_rx <= 1'b0;
        if (idle_ifs)
          gate_tx <= 1'b0;
      end
      // bus stuck active far beyond any symbol: arbitration lost too
      if (state != S_RESET && tx_full && tick && line_q
          && width_cnt == 10'h3FF) begin
        invalid_sym <= 1'b1;
        arbitration_lost_flag <= 1'b1;
      end
      if (edge_seen && !digital_loopback && !analog_loopback && state == S_IDLE && cpu_wait_i)
        wake_flag <= 1'b1;
      if (state == S_RX && tick && edge_seen && !gate_rx) begin
        shreg <= {shreg[6:0], (width_cnt < `T_BIT_MID_US) ^ line_q};
        bit_cnt <= bit_cnt + 4'h1;
        crc <= {crc[6:0], 1'b0} ^
          ((crc[7] ^ ((width_cnt < `T_BIT_MID_US) ^ line_q)) ? 8'h1D : 8'h00);
        if (bit_cnt == 4'h7) begin
          bit_cnt <= 4'h0;
          rx_hold <= {shreg[6:0], (width_cnt < `T_BIT_MID_US) ^ line_q};
          receive_full_flag <= 1'b1;
        end
      end
      if (state == S_RX && idle_eof) begin
        eof_seen <= 1'b1;
        if (bit_cnt != 4'h0)
          invalid_sym <= 1'b1;
        else if (crc != 8'hC4)
          crc_err <= 1'b1;
      end
      if (is_break && state != S_RESET)
        invalid_sym <= 1'b1;
      if (state == S_TX && next_state == S_WAIT_EOF)
        invalid_sym <= 1'b1;
      if (tick && echo_wait != 4'h0)
        echo_wait <= echo_wait - 4'h1;
      if (state == S_IDLE && next_state == S_TX) begin
        tx_shreg <= link_data_register;
        bit_cnt <= 4'h0;
        tx_level <= 1'b1;
        tx_len <= `T_SOF_US;
        echo_wait <= `T_ECHO_US;
      end else if (state == S_TX && tick) begin
        if (tx_len != 10'h000) begin
          tx_len <= tx_len - 10'h001;
        end else if (bit_cnt == 4'h8) begin
          tx_level <= 1'b0;
        end else begin
          tx_level <= ~tx_level;
          echo_wait <= `T_ECHO_US;
          tx_len <= (tx_shreg[7] ^ tx_level) ? `T_LONG_US : `T_SHORT_US;
          tx_shreg <= {tx_shreg[6:0], 1'b0};
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (state != S_TX) begin
        tx_level <= 1'b0;
      end
      transmit_pin_o <= tx_level & ~analog_loopback & ~digital_loopback;
      if (state == S_RX && idle_eof)
        bit_cnt <= 4'h0;
      if (state == S_RESET) begin
        bit_cnt <= 4'h0;
        crc <= 8'hFF;
      end
      if (state == S_IDLE && is_sof)
        crc <= 8'hFF;
      if (rd_sv && clk_en_i) begin
        if (wake_flag)
          wake_flag <= 1'b0;
        else if (invalid_sym)
          invalid_sym <= 1'b0;
        else if (crc_err)
          crc_err <= 1'b0;
        else if (eof_seen && !receive_full_flag)
          eof_seen <= 1'b0;
      end
      if (rd_dr && clk_en_i)
        receive_full_flag <= 1'b0;
      // ignore mode holds all status bits except wake_flag and tx_full at reset value
      if (ignore_message) begin
        receive_full_flag <= 1'b0;
        crc_err <= 1'b0;
        invalid_sym <= 1'b0;
        eof_seen <= 1'b0;
        arbitration_lost_flag <= 1'b0;
      end
    end
  end
  // vector is never cleared by irq enable writes; flags persist
endmodule

// ---- testbench/vpw_link_checker.sv ----
// port checker for the vpw link controller
`timescale 1ns/100ps
`include "vpw_link_map.vh"
module vpw_link_checker (
  input wire clk_i,
  input wire rst_n_i,
  input wire clk_en_i,
  input wire cpu_wait_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire receive_pin_i,
  input wire final_stage_i,
  input wire transmit_pin_o,
  input wire xcvr_loop_o,
  input wire irq_o
);
  // shadow of software writes; bit 7 of c1 follows writes only, the hardware clear of it is not tracked
  reg [7:0] c1;
  reg [7:0] c2;
  reg locked;
  reg loaded;
  wire w1 = wr_i && clk_en_i && addr_i == `ADDR_CTRL_ONE;
  wire w2 = wr_i && clk_en_i && addr_i == `ADDR_CTRL_TWO;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      c1 <= `CTRL_ONE_RST;
      c2 <= `CTRL_TWO_RST;
      locked <= 1'b0;
      loaded <= 1'b0;
    end else begin
      if (w1) begin
        c1 <= locked ? {wdata_i[7:6], c1[5:4], wdata_i[3:0]} : wdata_i;
        locked <= 1'b1;
      end
      if (w2) begin
        c2 <= wdata_i;
      end
      if (wr_i && clk_en_i && addr_i == `ADDR_DATA) begin
        loaded <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence rd_one;
    rd_i && clk_en_i && addr_i == `ADDR_CTRL_ONE;
  endsequence
  sequence rd_two;
    rd_i && clk_en_i && addr_i == `ADDR_CTRL_TWO;
  endsequence
  rate_held_a: assert property (rd_one ##0 locked |=>
    rdata_o[5:4] == c1[5:4]) else $error("rate bits changed after lock");
  loop_bits_a: assert property (rd_two |=>
    rdata_o[7:6] == c2[7:6]) else $error("loopback bits read wrong");
  loop_pin_a: assert property (xcvr_loop_o == c2[7])
    else $error("loop output differs from control bit");
  loop_quiet_a: assert property ($rose(xcvr_loop_o) |->
    ##1 !transmit_pin_o [*4]) else $error("bus driven in analog loop");
  irq_gate_a: assert property (!c1[1] |-> !irq_o)
    else $error("irq raised with enable clear");
  irq_hold_a: assert property (c1[1] && irq_o && !rd_i && !wr_i
    |=> irq_o) else $error("irq dropped without register action");
  wait_freeze_a: assert property (cpu_wait_i && c1[0] && !wr_i && !rd_i
    |=> $stable(transmit_pin_o) && $stable(irq_o))
    else $error("core ran during wait with clocks stopped");
  digital_loopback_quiet_a: assert property (c2[6] && !loaded && !irq_o
    |=> !irq_o) else $error("irq from bus in digital loop");
  enable_freeze_a: assert property (!clk_en_i |=>
    $stable(transmit_pin_o) && $stable(irq_o)) else $error("state moved");
  unmapped_a: assert property (rd_i && clk_en_i && addr_i > 3'h4 |=>
    rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule
bind vpw_link_controller vpw_link_checker chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .cpu_wait_i(cpu_wait_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .receive_pin_i(receive_pin_i),
  .final_stage_i(final_stage_i), .transmit_pin_o(transmit_pin_o),
  .xcvr_loop_o(xcvr_loop_o), .irq_o(irq_o));

// ---- testbench/vpw_xcvr_model.sv ----
// transceiver model: bus wire, stuck-active fault, analog loop path
`timescale 1ns/100ps
module vpw_xcvr_model (
  input wire tx_i,
  input wire loop_i,
  input wire stuck_i,
  output wire rx_o,
  output wire final_o
);
  // passive bus is pulled low; in loop the drive stage is cut off the bus
  assign rx_o = stuck_i | (tx_i & !loop_i);
  assign final_o = tx_i;
endmodule

// ---- testbench/vpw_link_controller_bench.sv ----
// self-checking bench for the vpw link controller
`timescale 1ns/100ps
`include "vpw_link_map.vh"
module vpw_link_controller_bench;
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg clk_en_i = 1'b1;
  reg cpu_wait_i = 1'b0;
  reg [2:0] addr_i = 3'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg stuck = 1'b0;
  wire [7:0] rdata_o;
  wire receive_pin_i;
  wire final_stage_i;
  wire transmit_pin_o;
  wire xcvr_loop_o;
  wire irq_o;
  integer errors = 0;
  integer samples_checked = 0;
  integer cycles = 0;
  integer i;
  always #25 clk_i = !clk_i;
  vpw_link_controller dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .cpu_wait_i(cpu_wait_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .receive_pin_i(receive_pin_i), .final_stage_i(final_stage_i),
    .transmit_pin_o(transmit_pin_o), .xcvr_loop_o(xcvr_loop_o),
    .irq_o(irq_o));
  vpw_xcvr_model xcvr (.tx_i(transmit_pin_o), .loop_i(xcvr_loop_o),
    .stuck_i(stuck), .rx_o(receive_pin_i), .final_o(final_stage_i));
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task do_reset;
    begin
      rst_n_i <= 1'b0;
      idle(6);
      rst_n_i <= 1'b1;
      idle(1);
    end
  endtask
  // a gap cycle follows each access so a strobe is never set twice at once
  task wr(input [2:0] a, input [7:0] d);
    begin
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      idle(1);
      wr_i <= 1'b0;
      idle(1);
    end
  endtask
  task rd(input [2:0] a, input [7:0] exp, input string nm);
    begin
      rd_i <= 1'b1;
      addr_i <= a;
      idle(1);
      rd_i <= 1'b0;
      #1 check(nm, rdata_o, exp);
      idle(1);
    end
  endtask
  // bus held active far beyond a break symbol, then long idle for eof/ifs
  task bus_break;
    begin
      stuck <= 1'b1;
      idle(6000);
      stuck <= 1'b0;
      idle(8000);
    end
  endtask
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    do_reset;
    rd(`ADDR_CTRL_ONE, `CTRL_ONE_RST, "ctrl_one");
    rd(`ADDR_CTRL_TWO, `CTRL_TWO_RST, "ctrl_two");
    rd(`ADDR_STATE_VEC, {2'b00, `SV_NONE}, "vector");
    for (i = 3; i >= 0; i = i - 1) begin
      do_reset;
      wr(`ADDR_CTRL_ONE, {2'b01, i[1:0], 4'h0});
      wr(`ADDR_CTRL_ONE, {2'b00, ~i[1:0], 4'h1});
      rd(`ADDR_CTRL_ONE, {2'b00, i[1:0], 4'h1}, "rate");
    end
    cpu_wait_i <= 1'b1;
    idle(20);
    cpu_wait_i <= 1'b0;
    clk_en_i <= 1'b0;
    idle(10);
    clk_en_i <= 1'b1;
    wr(`ADDR_POLARITY, 8'h80);
    rd(`ADDR_POLARITY, 8'h80, "polarity");
    rd(3'h5, 8'h00, "unmapped");
    wr(3'h6, 8'hFF);
    wr(`ADDR_CTRL_TWO, 8'h40);
    #1 check("loop_pin", {7'h00, xcvr_loop_o}, 8'h00);
    rd(`ADDR_CTRL_TWO, 8'h40, "ctrl_two");
    wr(`ADDR_CTRL_TWO, 8'h80);
    #1 check("loop_pin", {7'h00, xcvr_loop_o}, 8'h01);
    check("tx_pin", {7'h00, transmit_pin_o}, 8'h00);
    wr(`ADDR_CTRL_TWO, 8'h00);
    idle(8000);
    wr(`ADDR_CTRL_ONE, 8'h02);
    bus_break;
    #1 check("irq", {7'h00, irq_o}, 8'h01);
    rd(`ADDR_STATE_VEC, {2'b00, `SV_INVALID}, "vector");
    #1 check("irq", {7'h00, irq_o}, 8'h00);
    wr(`ADDR_CTRL_ONE, 8'h00);
    bus_break;
    #1 check("irq", {7'h00, irq_o}, 8'h00);
    rd(`ADDR_STATE_VEC, {2'b00, `SV_INVALID}, "vector");
    wr(`ADDR_CTRL_ONE, 8'h82);
    rd(`ADDR_STATE_VEC, {2'b00, `SV_NONE}, "vector");
    stuck <= 1'b1;
    wr(`ADDR_DATA, 8'hA5);
    idle(6000);
    #1 check("tx_pin", {7'h00, transmit_pin_o}, 8'h00);
    check("irq", {7'h00, irq_o}, 8'h01);
    stuck <= 1'b0;
    idle(8000);
    rd(`ADDR_CTRL_ONE, 8'h02, "ctrl_one");
    rd(`ADDR_STATE_VEC, {2'b00, `SV_INVALID}, "vector");
    tally_and_finish;
  end
endmodule
